// [rtl/olr_consts.vh]
// constants for the one-time-programmable readback command block
// assumes a byte-level frame layer delivers identifiers and data bytes
`ifndef OLR_CONSTS_VH
`define OLR_CONSTS_VH

// frame identifiers as they appear in the header byte
`define OLR_ID_MASTER_REQ 8'h3C
`define OLR_ID_SLAVE_RSP 8'h7D

// request layout
`define OLR_APP_CMD_MARKER 8'h80
`define OLR_CMD_READ_FIRST 7'h04
`define OLR_CMD_READ_SECOND 7'h05
`define OLR_REQ_LAST_IDX 4'h8
`define OLR_RSP_LAST_DATA_IDX 4'h7
`define OLR_RSP_CSUM_IDX 4'h8

// fill values and checksum target
`define OLR_FILL_BYTE 8'hFF
`define OLR_CSUM_GOOD 8'hFF
`define OLR_RSP_NONE 2'h0
`define OLR_RSP_FIRST 2'h1
`define OLR_RSP_SECOND 2'h2

`endif

// [rtl/olr_otp_readback.v]
// command handling for reading back the stored configuration over a LIN slave link
// assumes a frame layer ahead of it that reports each header identifier and each
// received byte as a one-cycle strobe, and sends response bytes with a valid/ready pair
`timescale 1ns/100ps
`include "olr_consts.vh"

// Operation
// - Requests arrive in a 0x3C master frame and the answer goes out only if the very next header is the response header.
// - The two answers together return every stored flag, address, lock bit, option, group and coefficient.
// - Every request and answer ends with a classic checksum over the data bytes only.
// - The first answer carries coefficients a11, a12, a13 in data bytes six to eight.
// - The second answer carries a21, a22, a23, a31, a32, a33 in data bytes two to seven.
// - With the lockout bit programmed, commands in master frames are neither evaluated nor acted upon.
module olr_otp_readback #(
  parameter COEF_COUNT = 9
) (
  input wire clk_sys,
  input wire nrst,
  input wire rx_id_valid,
  input wire [7:0] rx_id,
  input wire rx_byte_valid,
  input wire [7:0] rx_byte,
  input wire tx_ready,
  input wire [5:0] otp_node_addr,
  input wire otp_low_baud,
  input wire otp_diag_all_off,
  input wire otp_default,
  input wire otp_err_off,
  input wire otp_tw_prog,
  input wire otp_lock_first,
  input wire otp_lock_second,
  input wire command_lockout_bit,
  input wire modulation_frequency_select,
  input wire thermal_option,
  input wire [3:0] group_identifier,
  input wire [8*COEF_COUNT-1:0] otp_coef,
  output reg tx_valid_r,
  output reg [7:0] tx_byte_r,
  output reg fwd_cmd_valid_r,
  output reg [6:0] fwd_cmd_code_r,
  output reg [7:0] fwd_cmd_addr_r
);

  localparam ST_IDLE = 3'b001;
  localparam ST_RXREQ = 3'b010;
  localparam ST_TXRSP = 3'b100;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [3:0] idx_r;
  reg [3:0] idx_nxt;
  reg [7:0] sum_r;
  reg [7:0] sum_nxt;
  reg [7:0] d1_r;
  reg [7:0] d1_nxt;
  reg [7:0] d2_r;
  reg [7:0] d2_nxt;
  reg [7:0] d3_r;
  reg [7:0] d3_nxt;
  reg [1:0] pend_r;
  reg [1:0] pend_nxt;
  reg [1:0] sel_r;
  reg [1:0] sel_nxt;
  reg tx_valid_nxt;
  reg [7:0] tx_byte_nxt;
  reg fwd_valid_nxt;
  reg [6:0] fwd_code_nxt;
  reg [7:0] fwd_addr_nxt;
  reg [7:0] sum_add;
  wire [7:0] coef [0:COEF_COUNT-1];

  // coefficients stored row by row, a11 in the lowest byte
  genvar gi;
  generate
    for (gi = 0; gi < COEF_COUNT; gi = gi + 1) begin : g_coef
      assign coef[gi] = otp_coef[8*gi +: 8];
    end
  endgenerate

  // classic checksum step: add with end-around carry
  function [7:0] csum_add;
    input [7:0] a;
    input [7:0] b;
    reg [8:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      csum_add = s[7:0] + {7'h00, s[8]};
    end
  endfunction

  function [7:0] rsp_byte;
    input [1:0] sel;
    input [3:0] idx;
    begin
      rsp_byte = `OLR_FILL_BYTE;
      if (sel == `OLR_RSP_FIRST) begin
        case (idx)
          4'h0: rsp_byte = {2'b11, otp_node_addr};
          4'h1: rsp_byte = {6'h3F, otp_low_baud, otp_diag_all_off};
          4'h2: rsp_byte = `OLR_FILL_BYTE;
          4'h3: rsp_byte = {otp_default, otp_err_off, otp_tw_prog, 5'h1F};
          4'h4: rsp_byte = {otp_lock_first, command_lockout_bit, otp_node_addr};
          4'h5: rsp_byte = coef[0];
          4'h6: rsp_byte = coef[1];
          4'h7: rsp_byte = coef[2];
          default: rsp_byte = `OLR_FILL_BYTE;
        endcase
      end else begin
        case (idx)
          4'h0: rsp_byte = {2'b11, otp_node_addr};
          4'h1: rsp_byte = coef[3];
          4'h2: rsp_byte = coef[4];
          4'h3: rsp_byte = coef[5];
          4'h4: rsp_byte = coef[6];
          4'h5: rsp_byte = coef[7];
          4'h6: rsp_byte = coef[8];
          4'h7: rsp_byte = {otp_lock_second, modulation_frequency_select, 1'b1, thermal_option, group_identifier};
          default: rsp_byte = `OLR_FILL_BYTE;
        endcase
      end
    end
  endfunction

  // next-state logic; a new header always wins over whatever is in progress
  always @* begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    sum_nxt = sum_r;
    d1_nxt = d1_r;
    d2_nxt = d2_r;
    d3_nxt = d3_r;
    pend_nxt = pend_r;
    sel_nxt = sel_r;
    tx_valid_nxt = tx_valid_r;
    tx_byte_nxt = tx_byte_r;
    fwd_valid_nxt = 1'b0;
    fwd_code_nxt = fwd_cmd_code_r;
    fwd_addr_nxt = fwd_cmd_addr_r;
    sum_add = 8'h00;
    if (rx_id_valid) begin
      tx_valid_nxt = 1'b0;
      pend_nxt = `OLR_RSP_NONE;
      state_nxt = ST_IDLE;
      // answer only in the header right after the request
      if (rx_id == `OLR_ID_SLAVE_RSP && pend_r != `OLR_RSP_NONE) begin
        state_nxt = ST_TXRSP;
        sel_nxt = pend_r;
        idx_nxt = 4'h0;
        sum_nxt = 8'h00;
        tx_valid_nxt = 1'b1;
        tx_byte_nxt = rsp_byte(pend_r, 4'h0);
      end else if (rx_id == `OLR_ID_MASTER_REQ) begin
        state_nxt = ST_RXREQ;
        idx_nxt = 4'h0;
        sum_nxt = 8'h00;
      end
    end else begin
      case (state_r)
        ST_IDLE: begin
          state_nxt = ST_IDLE;
        end
        ST_RXREQ: begin
          if (rx_byte_valid) begin
            sum_add = csum_add(sum_r, rx_byte);
            sum_nxt = sum_add;
            idx_nxt = idx_r + 4'h1;
            if (idx_r == 4'h0) d1_nxt = rx_byte;
            if (idx_r == 4'h1) d2_nxt = rx_byte;
            if (idx_r == 4'h2) d3_nxt = rx_byte;
            if (idx_r == `OLR_REQ_LAST_IDX) begin
              state_nxt = ST_IDLE;
              // data plus checksum must fold to all ones
              // lockout drops the command before any decode
              if (sum_add == `OLR_CSUM_GOOD && !command_lockout_bit && d1_r == `OLR_APP_CMD_MARKER) begin
                // read commands need the address to match the stored one; other commands forward without a match
                if (d2_r[6:0] == `OLR_CMD_READ_FIRST) begin
                  if (d3_r[5:0] == otp_node_addr) pend_nxt = `OLR_RSP_FIRST;
                end else if (d2_r[6:0] == `OLR_CMD_READ_SECOND) begin
                  if (d3_r[5:0] == otp_node_addr) pend_nxt = `OLR_RSP_SECOND;
                end else begin
                  fwd_valid_nxt = 1'b1;
                  fwd_code_nxt = d2_r[6:0];
                  fwd_addr_nxt = d3_r;
                end
              end
            end
          end
        end
        ST_TXRSP: begin
          if (tx_valid_r && tx_ready) begin
            sum_add = csum_add(sum_r, tx_byte_r);
            sum_nxt = sum_add;
            idx_nxt = idx_r + 4'h1;
            if (idx_r == `OLR_RSP_CSUM_IDX) begin
              tx_valid_nxt = 1'b0;
              state_nxt = ST_IDLE;
            end else if (idx_r == `OLR_RSP_LAST_DATA_IDX) begin
              // inverted sum over the eight data bytes, identifier excluded
              tx_byte_nxt = ~sum_add;
            end else begin
              tx_byte_nxt = rsp_byte(sel_r, idx_r + 4'h1);
            end
          end
        end
        default: begin
          state_nxt = ST_IDLE;
          tx_valid_nxt = 1'b0;
        end
      endcase
    end
  end

  // state registers; inputs are already synchronous, so no extra staging
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
      idx_r <= 4'h0;
      sum_r <= 8'h00;
      d1_r <= 8'h00;
      d2_r <= 8'h00;
      d3_r <= 8'h00;
      pend_r <= `OLR_RSP_NONE;
      sel_r <= `OLR_RSP_NONE;
      tx_valid_r <= 1'b0;
      tx_byte_r <= 8'h00;
      fwd_cmd_valid_r <= 1'b0;
      fwd_cmd_code_r <= 7'h00;
      fwd_cmd_addr_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      sum_r <= sum_nxt;
      d1_r <= d1_nxt;
      d2_r <= d2_nxt;
      d3_r <= d3_nxt;
      pend_r <= pend_nxt;
      sel_r <= sel_nxt;
      tx_valid_r <= tx_valid_nxt;
      tx_byte_r <= tx_byte_nxt;
      fwd_cmd_valid_r <= fwd_valid_nxt;
      fwd_cmd_code_r <= fwd_code_nxt;
      fwd_cmd_addr_r <= fwd_addr_nxt;
    end
  end

endmodule // olr_otp_readback

// [verification/olr_lin_master_model.sv]
// bus master model: sends request frames, collects answers
// assumes the frame layer hands bytes as one-cycle strobes
`timescale 1ns/100ps
module olr_lin_master_model (
  input wire clk_sys,
  input wire tx_valid_r,
  input wire [7:0] tx_byte_r,
  output reg rx_id_valid,
  output reg [7:0] rx_id,
  output reg rx_byte_valid,
  output reg [7:0] rx_byte,
  output reg tx_ready
);
  reg [7:0] got [0:8];
  integer n;
  // idle lines at time zero
  initial begin
    {rx_id_valid, rx_id, rx_byte_valid, rx_byte, tx_ready} = 19'h0_0000;
    n = 0;
  end
  function [7:0] add(input [7:0] s, input [7:0] b);
    reg [8:0] t;
    begin
      t = s + b;
      add = t[7:0] + t[8];
    end
  endfunction
  // one header strobe, id inverted after so it never looks stale
  task hdr(input [7:0] id);
    begin
      @(posedge clk_sys);
      rx_id_valid <= 1'h1;
      rx_id <= id;
      @(posedge clk_sys);
      rx_id_valid <= 1'h0;
      rx_id <= ~id;
    end
  endtask
  // request frame, bad spoils the checksum
  task req(input [6:0] code, input [5:0] ad, input bad);
    reg [7:0] b;
    reg [7:0] s;
    integer i;
    begin
      hdr(8'h3C);
      s = 8'h00;
      for (i = 0; i < 9; i = i + 1) begin
        b = i == 0 ? 8'h80 : i == 1 ? {1'h1, code} : i == 2 ? {2'h3, ad} : 8'hFF;
        if (i == 8) b = ~s ^ {7'h00, bad};
        s = add(s, b);
        rx_byte_valid <= 1'h1;
        rx_byte <= b;
        @(posedge clk_sys);
      end
      rx_byte_valid <= 1'h0;
      rx_byte <= ~b;
    end
  endtask
  // response slot, stalls every other cycle, bounded
  task rsp;
    integer k;
    begin
      hdr(8'h7D);
      n = 0;
      for (k = 0; k < 40 && n < 9; k = k + 1) begin
        tx_ready <= k[0];
        @(posedge clk_sys);
        if (tx_valid_r && tx_ready) begin
          got[n] = tx_byte_r;
          n = n + 1;
        end
      end
      tx_ready <= 1'h0;
    end
  endtask
endmodule // olr_lin_master_model

// [verification/olr_otp_readback_assertions.sv]
// checker for the readback command block, sees only its ports
// assumes one clock, async active-low reset, bound below
`timescale 1ns/100ps
module olr_otp_readback_assertions #(
  parameter COEF_COUNT = 9
) (
  input wire clk_sys,
  input wire nrst,
  input wire rx_id_valid,
  input wire [7:0] rx_id,
  input wire rx_byte_valid,
  input wire tx_ready,
  input wire [5:0] otp_node_addr,
  input wire command_lockout_bit,
  input wire tx_valid_r,
  input wire [7:0] tx_byte_r,
  input wire fwd_cmd_valid_r
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // the response header that may open an answer
  sequence s_rsp_hdr; rx_id_valid && rx_id == 8'h7D; endsequence
  property p_rsp_start; $rose(tx_valid_r) |-> $past(rx_id_valid && rx_id == 8'h7D); endproperty
  property p_first; s_rsp_hdr ##1 $rose(tx_valid_r) |-> tx_byte_r == {2'h3, otp_node_addr}; endproperty
  property p_hold; tx_valid_r && !tx_ready && !rx_id_valid |=> tx_valid_r && $stable(tx_byte_r); endproperty
  property p_drop; $fell(tx_valid_r) |-> $past(tx_ready || rx_id_valid); endproperty
  property p_lock_rsp; $rose(tx_valid_r) |-> !command_lockout_bit; endproperty
  property p_lock_fwd; fwd_cmd_valid_r |-> !command_lockout_bit; endproperty
  property p_fwd_src; fwd_cmd_valid_r |-> $past(rx_byte_valid) ##1 !fwd_cmd_valid_r; endproperty
  a_rsp_start: assert property (p_rsp_start) else $error("answer without response header");
  a_first: assert property (p_first) else $error("first answer byte wrong");
  a_hold: assert property (p_hold) else $error("answer byte not held");
  a_drop: assert property (p_drop) else $error("answer dropped untaken");
  a_lock_rsp: assert property (p_lock_rsp) else $error("answer while locked out");
  a_lock_fwd: assert property (p_lock_fwd) else $error("forward while locked out");
  a_fwd_src: assert property (p_fwd_src) else $error("forward strobe wrong");
endmodule // olr_otp_readback_assertions

bind olr_otp_readback olr_otp_readback_assertions #(.COEF_COUNT(COEF_COUNT)) chk_i (.clk_sys(clk_sys),
  .nrst(nrst), .rx_id_valid(rx_id_valid), .rx_id(rx_id), .rx_byte_valid(rx_byte_valid), .tx_ready(tx_ready),
  .otp_node_addr(otp_node_addr), .command_lockout_bit(command_lockout_bit), .tx_valid_r(tx_valid_r),
  .tx_byte_r(tx_byte_r), .fwd_cmd_valid_r(fwd_cmd_valid_r));

// [verification/olr_otp_readback_tb_top.sv]
// testbench for the readback command block
// assumes the master model drives every bus-side input
`timescale 1ns/100ps
module olr_otp_readback_tb_top;
  reg clk_sys = 0;
  reg nrst = 0;
  reg lk = 0;
  reg [8:0] f = 9'h0A5;
  reg [5:0] ad = 6'h2A;
  reg [3:0] grp = 4'h9;
  reg [71:0] coef = 72'h99_8877_6655_4433_2211;
  wire rx_id_valid, rx_byte_valid, tx_ready, tx_valid_r, fwd_cmd_valid_r;
  wire [7:0] rx_id, rx_byte, tx_byte_r;
  wire [6:0] fwd_cmd_code_r;
  wire [7:0] fwd_cmd_addr_r;
  integer fails = 0;
  integer num_checks = 0;
  // 200 MHz clock
  always #2.5 clk_sys = ~clk_sys;
  olr_lin_master_model m (.clk_sys(clk_sys), .tx_valid_r(tx_valid_r), .tx_byte_r(tx_byte_r),
    .rx_id_valid(rx_id_valid), .rx_id(rx_id), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .tx_ready(tx_ready));
  olr_otp_readback olr_otp_readback_i (.clk_sys(clk_sys), .nrst(nrst), .rx_id_valid(rx_id_valid), .rx_id(rx_id),
    .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .tx_ready(tx_ready), .otp_node_addr(ad),
    .otp_low_baud(f[0]), .otp_diag_all_off(f[1]), .otp_default(f[2]), .otp_err_off(f[3]), .otp_tw_prog(f[4]),
    .otp_lock_first(f[5]), .otp_lock_second(f[6]), .command_lockout_bit(lk), .modulation_frequency_select(f[7]),
    .thermal_option(f[8]), .group_identifier(grp), .otp_coef(coef), .tx_valid_r(tx_valid_r), .tx_byte_r(tx_byte_r),
    .fwd_cmd_valid_r(fwd_cmd_valid_r), .fwd_cmd_code_r(fwd_cmd_code_r), .fwd_cmd_addr_r(fwd_cmd_addr_r));
  task chk(input [7:0] g, input [7:0] e);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  // whole answer: count, eight data bytes, then the checksum
  task ck_rsp(input [63:0] e);
    reg [7:0] s;
    integer i;
    begin
      s = 8'h00;
      chk(m.n[7:0], 8'h09);
      for (i = 0; i < 8; i = i + 1) begin
        chk(m.got[i], e[63-8*i -: 8]);
        s = m.add(s, e[63-8*i -: 8]);
      end
      chk(m.got[8], ~s);
    end
  endtask
  task t_read1;
    begin
      m.req(7'h04, ad, 1'h0);
      m.rsp;
      ck_rsp({2'h3, ad, 6'h3F, f[0], f[1], 8'hFF, f[2], f[3], f[4], 5'h1F, f[5], lk, ad,
        coef[7:0], coef[15:8], coef[23:16]});
    end
  endtask
  task t_read2;
    begin
      m.req(7'h05, ad, 1'h0);
      m.rsp;
      ck_rsp({2'h3, ad, coef[31:24], coef[39:32], coef[47:40], coef[55:48], coef[63:56], coef[71:64],
        f[6], f[7], 1'h1, f[8], grp});
    end
  endtask
  // wrong address and spoiled checksum both leave the slot empty
  task t_refuse;
    begin
      m.req(7'h04, ~ad, 1'h0);
      m.rsp;
      chk(m.n[7:0], 8'h00);
      m.req(7'h05, ad, 1'h1);
      m.rsp;
      chk(m.n[7:0], 8'h00);
    end
  endtask
  // lockout silences readback and forwarding alike
  task t_lock;
    begin
      m.req(7'h02, ad, 1'h0);
      // strobe launched at the checksum edge, looked at one edge later while it stands
      @(posedge clk_sys);
      chk({7'h00, fwd_cmd_valid_r}, 8'h01);
      chk({1'h0, fwd_cmd_code_r}, 8'h02);
      chk(fwd_cmd_addr_r, {2'h3, ad});
      lk <= 1'h1;
      m.req(7'h04, ad, 1'h0);
      m.rsp;
      chk(m.n[7:0], 8'h00);
      m.req(7'h06, ad, 1'h0);
      @(posedge clk_sys);
      chk({7'h00, fwd_cmd_valid_r}, 8'h00);
      chk({1'h0, fwd_cmd_code_r}, 8'h02);
      lk <= 1'h0;
    end
  endtask
  task results;
    begin
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  // main sequence, flags flipped before the second read; each flag is seen at one level only
  initial begin
    repeat (8) @(posedge clk_sys);
    nrst <= 1'h1;
    t_read1;
    f <= ~f;
    t_read2;
    t_refuse;
    t_lock;
    results;
  end
endmodule // olr_otp_readback_tb_top
